// >>> hdl/uetc_top.sv
// USB device transaction controller: control endpoint and five general endpoints.
// Assumes a packet engine on hclk reporting token start and end, and an AHB-Lite master.
`timescale 1ns/1ps
`include "uetc_params.svh"

// Behaviour
// auto_nak_arm sets hold_off_handshake after every completed OUT.
// short_pkt_permit allows short IN; cleared when that IN completes.
// short OUT sets hold_off_handshake unless short_rx_autonak_inhibit set.
// seq_toggle_state readable; force_one sets it, force_zero clears it.
// hold_off_handshake makes endpoint answer NAK regardless of FIFO.
// halt_handshake makes endpoint answer STALL.
// with usb_function_enable, every SETUP to control endpoint is accepted.
// valid SETUP stores eight bytes and answers ACK.
// valid SETUP raises setup_received_flag except for SetAddress.
// erroneous SETUP gets no handshake and no flag.
// valid SETUP sets both control NAKs, clears STALL, sets toggle and guard.
// firmware clears ctrl_ep_guard first, then the NAK it needs.
// OUT data accepted only if FIFO free space exceeds max packet.
// good OUT answers ACK or NYET, flags done, commits bytes.
// good short OUT also raises out_short_done_flag.
// toggle mismatch OUT answers ACK, no flag, no commit.
// OUT error gives no handshake, out_fault_flag, no commit.
// incompletely received OUT answers NAK, out_refused_flag, no commit.
// guard blocks firmware writes of control NAK and STALL bits.
// toggle flips on successful data transaction only.
// result flags per endpoint, sticky until firmware clears them.
module uetc_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  txn_start,
  input  wire logic                  txn_end,
  input  wire uetc_pkg::uetc_kind_t  txn_kind,
  input  wire logic [2:0]            txn_ep,
  input  wire logic [11:0]           fifo_free,
  input  wire logic [10:0]           max_pkt,
  input  wire logic                  in_full_pkt,
  input  wire logic                  rx_error,
  input  wire logic                  rx_mismatch,
  input  wire logic                  rx_incomplete,
  input  wire logic                  pkt_short,
  input  wire logic                  nyet_hint,
  input  wire logic                  set_address_req,
  input  wire logic                  setup_byte_valid,
  input  wire logic [7:0]            setup_byte,
  output logic                       data_accept,
  output logic                       hs_valid,
  output uetc_pkg::uetc_hs_t         hs_code,
  output logic                       fifo_commit,
  output logic [2:0]                 commit_ep
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic        wr_q;
  logic [7:0]  wa_q;
  logic        usb_function_enable;
  logic        ctrl_ep_guard;
  logic        setup_received_flag;
  logic [63:0] setup_byte_regs;
  logic [63:0] setup_shadow;
  logic [7:0]  ctrl [`UETC_NSLOT];
  logic [6:0]  flags [`UETC_NSLOT];
  logic        room_q;

  wire        addr_ph = hsel && htrans[1] && hready;
  wire [7:0]  ra      = haddr[7:0];
  wire [7:0]  ctl_off = 8'(wa_q - `UETC_A_CTL_BASE);
  wire [7:0]  flg_off = 8'(wa_q - `UETC_A_FLG_BASE);
  wire [7:0]  rctl    = 8'(ra - `UETC_A_CTL_BASE);
  wire [7:0]  rflg    = 8'(ra - `UETC_A_FLG_BASE);
  wire        wr_func = wr_q && (wa_q == `UETC_A_FUNC);
  wire        wr_grd  = wr_q && (wa_q == `UETC_A_GUARD);
  wire        wr_ctl  = wr_q && (ctl_off[7:2] < 6'(`UETC_NSLOT)) && (ctl_off[1:0] == 2'h0);
  wire        wr_flg  = wr_q && (flg_off[7:2] < 6'(`UETC_NSLOT)) && (flg_off[1:0] == 2'h0);
  wire        rd_ctl  = (rctl[7:2] < 6'(`UETC_NSLOT)) && (rctl[1:0] == 2'h0);
  wire        rd_flg  = (rflg[7:2] < 6'(`UETC_NSLOT)) && (rflg[1:0] == 2'h0);
  wire [2:0]  rci     = rctl[4:2];
  wire [2:0]  rfi     = rflg[4:2];
  // Strobe bits read as zero
  wire [7:0]  ctl_rd  = ctrl[rci] & ~(8'h01 << `UETC_B_TSET) & ~(8'h01 << `UETC_B_TCLR);
  wire [31:0] rd_data =
    (ra == `UETC_A_FUNC)     ? {31'h0, usb_function_enable} :
    (ra == `UETC_A_GUARD)    ? {30'h0, setup_received_flag, ctrl_ep_guard} :
    (ra == `UETC_A_SETUP_LO) ? setup_byte_regs[31:0] :
    (ra == `UETC_A_SETUP_HI) ? setup_byte_regs[63:32] :
    rd_ctl                   ? {24'h0, ctl_rd} :
    rd_flg                   ? {25'h0, flags[rfi]} : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      wa_q   <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_q <= addr_ph && hwrite;
      wa_q <= ra;
      if (addr_ph && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  // ****************************************************************
  // Transaction outcome
  // ****************************************************************
  wire [2:0] slot = (txn_ep != `UETC_EP_CTRL) ? 3'(txn_ep + 3'h1) :
                    (txn_kind == uetc_pkg::UETC_K_IN) ? 3'h0 : 3'h1;
  wire [7:0] cs       = ctrl[slot];
  wire       s_nak    = cs[`UETC_B_NAK];
  wire       s_stall  = cs[`UETC_B_STALL];
  wire       room     = {1'b0, fifo_free} > {2'b00, max_pkt};
  wire       is_setup = txn_end && (txn_kind == uetc_pkg::UETC_K_SETUP) &&
                        usb_function_enable && (txn_ep == `UETC_EP_CTRL);
  wire       setup_ok = is_setup && !rx_error;
  wire       is_out   = txn_end && (txn_kind == uetc_pkg::UETC_K_OUT);
  wire       is_in    = txn_end && (txn_kind == uetc_pkg::UETC_K_IN);
  wire       out_go   = is_out && !s_stall && !s_nak && !rx_error;
  wire       out_nak  = out_go && (!room_q || rx_incomplete);
  wire       out_mis  = out_go && !out_nak && rx_mismatch;
  wire       out_ok   = out_go && !out_nak && !rx_mismatch;
  wire       in_send  = is_in && !s_stall && !s_nak && (in_full_pkt || cs[`UETC_B_PERMIT]);
  wire       in_ok    = in_send && !rx_error;

  // Link samples this while the token is live, so it is combinational
  assign data_accept = (txn_kind == uetc_pkg::UETC_K_OUT) && room && !s_nak && !s_stall;

  uetc_pkg::uetc_hs_t next_hs;
  always_comb begin
    next_hs = uetc_pkg::UETC_HS_NONE;
    if (setup_ok) begin
      next_hs = uetc_pkg::UETC_HS_ACK;
    end else if ((is_out || is_in) && s_stall) begin
      next_hs = uetc_pkg::UETC_HS_STALL;
    end else if ((is_out || is_in) && s_nak) begin
      next_hs = uetc_pkg::UETC_HS_NAK;
    end else if (is_out && rx_error) begin
      next_hs = uetc_pkg::UETC_HS_NONE;
    end else if (out_nak || (is_in && !in_send)) begin
      next_hs = uetc_pkg::UETC_HS_NAK;
    end else if (out_mis) begin
      next_hs = uetc_pkg::UETC_HS_ACK;
    end else if (out_ok) begin
      next_hs = nyet_hint ? uetc_pkg::UETC_HS_NYET : uetc_pkg::UETC_HS_ACK;
    end else if (in_send) begin
      next_hs = uetc_pkg::UETC_HS_DATA;
    end
  end

  // Error SETUP and ignored SETUP both stay silent
  wire next_hs_valid = setup_ok || ((is_out || is_in) && (next_hs != uetc_pkg::UETC_HS_NONE));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_valid    <= 1'b0;
      hs_code     <= uetc_pkg::UETC_HS_NONE;
      fifo_commit <= 1'b0;
      commit_ep   <= 3'h0;
      room_q      <= 1'b0;
    end else begin
      hs_valid    <= next_hs_valid;
      hs_code     <= next_hs;
      fifo_commit <= out_ok;
      commit_ep   <= txn_ep;
      if (txn_start) begin
        room_q <= room;
      end
    end
  end

  // ****************************************************************
  // Setup capture and guard
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_shadow        <= 64'h0;
      setup_byte_regs     <= 64'h0;
      ctrl_ep_guard       <= 1'b0;
      setup_received_flag <= 1'b0;
      usb_function_enable <= 1'b0;
    end else begin
      if (setup_byte_valid) begin
        setup_shadow <= {setup_byte, setup_shadow[63:8]};
      end
      if (setup_ok) begin
        setup_byte_regs <= setup_shadow;
      end
      // Firmware may only clear the guard; hardware set wins
      ctrl_ep_guard <= setup_ok || (wr_grd ? (hwdata[0] && ctrl_ep_guard) : ctrl_ep_guard);
      setup_received_flag <= (setup_ok && !set_address_req) ||
                             (setup_received_flag && !(wr_grd && hwdata[1]));
      if (wr_func) begin
        usb_function_enable <= hwdata[0];
      end
    end
  end

  // ****************************************************************
  // Endpoint control and result flags
  // ****************************************************************
  logic [7:0] next_ctrl  [`UETC_NSLOT];
  logic [6:0] next_flags [`UETC_NSLOT];
  logic [6:0] fset;

  always_comb begin
    fset = 7'h00;
    fset[`UETC_F_ODONE]  = out_ok;
    fset[`UETC_F_OSHORT] = out_ok && pkt_short;
    fset[`UETC_F_OREF]   = (is_out && !s_stall && s_nak) || out_nak;
    fset[`UETC_F_OFAULT] = is_out && !s_stall && !s_nak && rx_error;
    fset[`UETC_F_IDONE]  = in_ok;
    fset[`UETC_F_IREF]   = is_in && !s_stall && !in_send;
    fset[`UETC_F_IFAULT] = in_send && rx_error;
    for (int i = 0; i < `UETC_NSLOT; i++) begin
      next_ctrl[i]  = ctrl[i];
      next_flags[i] = flags[i];
      if (wr_flg && (flg_off[4:2] == 3'(i))) begin
        next_flags[i] = flags[i] & ~hwdata[6:0];
      end
      if (slot == 3'(i)) begin
        next_flags[i] = next_flags[i] | fset;
      end
      if (wr_ctl && (ctl_off[4:2] == 3'(i))) begin
        if (!(i < 2 && ctrl_ep_guard)) begin
          next_ctrl[i][`UETC_B_STALL:`UETC_B_NAK] = hwdata[`UETC_B_STALL:`UETC_B_NAK];
        end
        next_ctrl[i][`UETC_B_INHIB:`UETC_B_ARM] = hwdata[`UETC_B_INHIB:`UETC_B_ARM];
        if (hwdata[`UETC_B_TSET]) begin
          next_ctrl[i][`UETC_B_TOG] = 1'b1;
        end else if (hwdata[`UETC_B_TCLR]) begin
          next_ctrl[i][`UETC_B_TOG] = 1'b0;
        end
      end
      if (setup_ok && i < 2) begin
        next_ctrl[i][`UETC_B_NAK]   = 1'b1;
        next_ctrl[i][`UETC_B_STALL] = 1'b0;
        next_ctrl[i][`UETC_B_TOG]   = 1'b1;
      end
      if (slot == 3'(i) && (out_ok || in_ok)) begin
        next_ctrl[i][`UETC_B_TOG] = !ctrl[i][`UETC_B_TOG];
      end
      if (slot == 3'(i) && out_ok && (ctrl[i][`UETC_B_ARM] ||
          (pkt_short && !ctrl[i][`UETC_B_INHIB]))) begin
        next_ctrl[i][`UETC_B_NAK] = 1'b1;
      end
      if (slot == 3'(i) && in_ok && !in_full_pkt) begin
        next_ctrl[i][`UETC_B_PERMIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `UETC_NSLOT; i++) begin
        ctrl[i]  <= `UETC_CTL_RST;
        flags[i] <= `UETC_FLG_RST;
      end
    end else begin
      ctrl  <= next_ctrl;
      flags <= next_flags;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence out_good_s;
    out_ok && !wr_q;
  endsequence

  nak_answer_a: assert property ((is_out || is_in) && !s_stall && s_nak |=> hs_valid && hs_code == uetc_pkg::UETC_HS_NAK)
    else $error("hold-off endpoint did not answer NAK");
  stall_answer_a: assert property ((is_out || is_in) && s_stall |=> hs_valid && hs_code == uetc_pkg::UETC_HS_STALL)
    else $error("halted endpoint did not answer STALL");
  setup_ack_a: assert property (setup_ok |=> hs_code == uetc_pkg::UETC_HS_ACK && ctrl_ep_guard && setup_byte_regs == $past(setup_shadow))
    else $error("valid setup not acknowledged and stored");
  setup_err_a: assert property (is_setup && rx_error && !setup_received_flag |=> !hs_valid && !setup_received_flag)
    else $error("erroneous setup answered or flagged");
  setup_ctl_a: assert property (setup_ok |=> ctrl[0][`UETC_B_NAK] && ctrl[1][`UETC_B_NAK] && !ctrl[1][`UETC_B_STALL])
    else $error("setup did not arm control endpoint NAK");
  out_commit_a: assert property (out_good_s |=> fifo_commit && flags[$past(slot)][`UETC_F_ODONE] ##1 !fifo_commit || out_ok)
    else $error("good OUT not committed and flagged");
  mismatch_ack_a: assert property (out_mis |=> hs_code == uetc_pkg::UETC_HS_ACK && !fifo_commit)
    else $error("toggle mismatch mishandled");
  out_fault_a: assert property (is_out && !s_stall && !s_nak && rx_error |=> !hs_valid && !fifo_commit && flags[$past(slot)][`UETC_F_OFAULT])
    else $error("OUT error mishandled");
  toggle_flip_a: assert property ((out_good_s and !setup_ok) |=> ctrl[$past(slot)][`UETC_B_TOG] != $past(cs[`UETC_B_TOG]))
    else $error("toggle did not flip after good OUT");
  auto_nak_a: assert property (out_ok && cs[`UETC_B_ARM] |=> ctrl[$past(slot)][`UETC_B_NAK])
    else $error("auto NAK arming failed");

endmodule : uetc_top

// >>> hdl/uetc_params.svh
// Offsets, bit positions and reset values of the transaction controller.
// Assumes a 32-bit AHB-Lite slave window decoded on haddr[7:0].
`ifndef UETC_PARAMS_SVH
`define UETC_PARAMS_SVH
`define UETC_A_FUNC     8'h00
`define UETC_A_GUARD    8'h04
`define UETC_A_SETUP_LO 8'h08
`define UETC_A_SETUP_HI 8'h0C
`define UETC_A_CTL_BASE 8'h20
`define UETC_A_FLG_BASE 8'h40
`define UETC_NSLOT      7
`define UETC_B_NAK      0
`define UETC_B_STALL    1
`define UETC_B_TOG      2
`define UETC_B_TSET     3
`define UETC_B_TCLR     4
`define UETC_B_ARM      5
`define UETC_B_PERMIT   6
`define UETC_B_INHIB    7
`define UETC_F_ODONE    0
`define UETC_F_OSHORT   1
`define UETC_F_OREF     2
`define UETC_F_OFAULT   3
`define UETC_F_IDONE    4
`define UETC_F_IREF     5
`define UETC_F_IFAULT   6
`define UETC_CTL_RST    8'h00
`define UETC_FLG_RST    7'h00
`define UETC_EP_CTRL    3'h0
`endif

// >>> hdl/uetc_pkg.sv
// Types shared by the transaction controller and its bench.
// Assumes nothing beyond the params header.
package uetc_pkg;
  typedef enum logic [1:0] {UETC_K_SETUP, UETC_K_OUT, UETC_K_IN} uetc_kind_t;
  typedef enum logic [2:0] {UETC_HS_NONE, UETC_HS_ACK, UETC_HS_NAK, UETC_HS_STALL,
                            UETC_HS_NYET, UETC_HS_DATA} uetc_hs_t;
endpackage : uetc_pkg

// >>> test/uetc_host_model.sv
// Host-side partner: sends tokens, setup bytes and transaction outcomes to the controller.
// Assumes the bench owns hclk and calls run for one transaction at a time.
`timescale 1ns/1ps
module uetc_host_model (
  input  wire logic                hclk,
  input  wire logic                hs_valid,
  input  wire uetc_pkg::uetc_hs_t  hs_code,
  input  wire logic                fifo_commit,
  input  wire logic [2:0]          commit_ep,
  input  wire logic                data_accept,
  output logic                     txn_start,
  output logic                     txn_end,
  output uetc_pkg::uetc_kind_t     txn_kind,
  output logic [2:0]               txn_ep,
  output logic [11:0]              fifo_free,
  output logic [10:0]              max_pkt,
  output logic                     in_full_pkt,
  output logic                     rx_error,
  output logic                     rx_mismatch,
  output logic                     rx_incomplete,
  output logic                     pkt_short,
  output logic                     nyet_hint,
  output logic                     set_address_req,
  output logic                     setup_byte_valid,
  output logic [7:0]               setup_byte
);
  logic [6:0] res;
  logic       got_v, got_cm, got_acc;
  logic [2:0] got_hs, got_cep;
  assign {in_full_pkt, rx_error, rx_mismatch, rx_incomplete, pkt_short, nyet_hint, set_address_req} = res;
  initial begin
    {txn_start, txn_end, txn_ep, fifo_free, max_pkt, res, setup_byte_valid, setup_byte} = '0;
    txn_kind = uetc_pkg::UETC_K_OUT;
  end
  task automatic run(input uetc_pkg::uetc_kind_t k, input logic [2:0] ep, input logic [11:0] fr,
                     input logic [10:0] mp, input logic [6:0] r, input logic [63:0] b);
    @(posedge hclk);
    txn_kind  <= k;
    txn_ep    <= ep;
    fifo_free <= fr;
    max_pkt   <= mp;
    txn_start <= 1'b1;
    @(posedge hclk);
    txn_start <= 1'b0;
    @(negedge hclk);
    got_acc = data_accept;
    if (k == uetc_pkg::UETC_K_SETUP) begin
      for (int i = 0; i < 8; i++) begin
        @(posedge hclk);
        setup_byte_valid <= 1'b1;
        setup_byte       <= b[8*i +: 8];
      end
    end
    @(posedge hclk);
    setup_byte_valid <= 1'b0;
    setup_byte       <= ~setup_byte;
    res              <= r;
    txn_end          <= 1'b1;
    @(posedge hclk);
    txn_end <= 1'b0;
    // Outcome lines are only valid at the end; scramble them afterwards
    res     <= ~r;
    @(negedge hclk);
    {got_v, got_hs, got_cm, got_cep} = {hs_valid, hs_code, fifo_commit, commit_ep};
  endtask : run
endmodule : uetc_host_model

// >>> test/usb_endpoint_transaction_ctrl_bench.sv
// Self-checking bench for the transaction controller: AHB-Lite register tasks plus a host model.
// Assumes the register map and result codes of the params header and package.
`timescale 1ns/1ps
`include "uetc_params.svh"
module usb_endpoint_transaction_ctrl_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, txn_start, txn_end, in_full_pkt, rx_error;
  logic rx_mismatch, rx_incomplete, pkt_short, nyet_hint, set_address_req, setup_byte_valid;
  logic data_accept, hs_valid, fifo_commit;
  logic [31:0] haddr, hwdata, hrdata, seed, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize, txn_ep, commit_ep, ep;
  logic [11:0] fifo_free;
  logic [10:0] max_pkt, mp;
  logic [7:0]  setup_byte, c, w;
  logic [63:0] b;
  logic [18:0] e;
  uetc_pkg::uetc_kind_t txn_kind;
  uetc_pkg::uetc_hs_t   hs_code;
  int failures, n_tests, cs;

  uetc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .txn_start, .txn_end, .txn_kind, .txn_ep, .fifo_free, .max_pkt,
    .in_full_pkt, .rx_error, .rx_mismatch, .rx_incomplete, .pkt_short, .nyet_hint, .set_address_req,
    .setup_byte_valid, .setup_byte, .data_accept, .hs_valid, .hs_code, .fifo_commit, .commit_ep);
  uetc_host_model i_host (.hclk, .hs_valid, .hs_code, .fifo_commit, .commit_ep, .data_accept, .txn_start,
    .txn_end, .txn_kind, .txn_ep, .fifo_free, .max_pkt, .in_full_pkt, .rx_error, .rx_mismatch,
    .rx_incomplete, .pkt_short, .nyet_hint, .set_address_req, .setup_byte_valid, .setup_byte);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Expected {handshake, flags, control after, commit} for an OUT with control c and case k
  function automatic logic [18:0] exp_out(input logic [7:0] c, input int k);
    logic [2:0] h;
    logic [6:0] f;
    logic [7:0] n;
    logic       cm;
    {h, f, n, cm} = {uetc_pkg::UETC_HS_ACK, 7'h00, c, 1'b0};
    if (c[1]) h = uetc_pkg::UETC_HS_STALL;
    else if (c[0]) {h, f} = {uetc_pkg::UETC_HS_NAK, 7'h04};
    else if (k == 3) {h, f} = {uetc_pkg::UETC_HS_NONE, 7'h08};
    else if (k == 4 || k == 5) {h, f} = {uetc_pkg::UETC_HS_NAK, 7'h04};
    else if (k != 2) begin
      h = (k == 6) ? uetc_pkg::UETC_HS_NYET : uetc_pkg::UETC_HS_ACK;
      f = {5'h00, k == 1, 1'b1};
      cm = 1'b1;
      n[2] = ~c[2];
      if (c[5] || (k == 1 && !c[7])) n[0] = 1'b1;
    end
    return {h, f, n, cm};
  endfunction : exp_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    {hsel, haddr, hwrite, htrans} <= {1'b1, 24'h000000, a, wr, 2'h2};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h00000000);
    check(v, exp);
    check({hreadyout, hresp}, 2'b10);
  endtask : rdc
  task automatic print_verdict();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  initial begin
    {hresetn, hsel, haddr, hwrite, htrans, hwdata, failures, n_tests} = '0;
    hsize = 3'h2;
    seed = 32'hAAE93612;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h28, 32'h00000000);
    bus(8'h80, 1'b1, 32'hFFFFFFFF);
    rdc(8'h80, 32'h00000000);
    i_host.run(uetc_pkg::UETC_K_SETUP, 3'h0, 12'h000, 11'h000, 7'h00, 64'h0);
    check(i_host.got_v, 1'b0);
    bus(`UETC_A_FUNC, 1'b1, 32'h00000001);
    b = {xs(seed), xs(~seed)};
    i_host.run(uetc_pkg::UETC_K_SETUP, 3'h0, 12'h000, 11'h000, 7'h00, b);
    check({i_host.got_v, i_host.got_hs}, {1'b1, uetc_pkg::UETC_HS_ACK});
    rdc(`UETC_A_SETUP_LO, b[31:0]);
    rdc(`UETC_A_SETUP_HI, b[63:32]);
    rdc(`UETC_A_GUARD, 32'h00000003);
    rdc(8'h20, 32'h00000005);
    bus(8'h24, 1'b1, 32'h00000000);
    rdc(8'h24, 32'h00000005);
    bus(`UETC_A_GUARD, 1'b1, 32'h00000002);
    bus(8'h24, 1'b1, 32'h00000002);
    rdc(8'h24, 32'h00000006);
    i_host.run(uetc_pkg::UETC_K_SETUP, 3'h0, 12'h000, 11'h000, 7'h01, ~b);
    check({i_host.got_v, i_host.got_hs}, {1'b1, uetc_pkg::UETC_HS_ACK});
    rdc(8'h24, 32'h00000005);
    rdc(`UETC_A_GUARD, 32'h00000001);
    bus(`UETC_A_GUARD, 1'b1, 32'h00000002);
    i_host.run(uetc_pkg::UETC_K_SETUP, 3'h0, 12'h000, 11'h000, 7'h20, b);
    check(i_host.got_v, 1'b0);
    rdc(`UETC_A_GUARD, 32'h00000000);
    bus(8'h2C, 1'b1, 32'h00000008);
    rdc(8'h2C, 32'h00000004);
    bus(8'h2C, 1'b1, 32'h00000010);
    rdc(8'h2C, 32'h00000000);
    bus(8'h28, 1'b1, 32'h00000050);
    i_host.run(uetc_pkg::UETC_K_IN, 3'h1, 12'h000, 11'h000, 7'h00, 64'h0);
    check({i_host.got_v, i_host.got_hs}, {1'b1, uetc_pkg::UETC_HS_DATA});
    rdc(8'h48, 32'h00000010);
    rdc(8'h28, 32'h00000004);
    i_host.run(uetc_pkg::UETC_K_IN, 3'h1, 12'h000, 11'h000, 7'h00, 64'h0);
    check({i_host.got_v, i_host.got_hs}, {1'b1, uetc_pkg::UETC_HS_NAK});
    rdc(8'h48, 32'h00000030);
    // Short IN that the host never acknowledges: fault flag, toggle and permit kept
    bus(8'h28, 1'b1, 32'h00000040);
    i_host.run(uetc_pkg::UETC_K_IN, 3'h1, 12'h000, 11'h000, 7'h20, 64'h0);
    check({i_host.got_v, i_host.got_hs}, {1'b1, uetc_pkg::UETC_HS_DATA});
    rdc(8'h48, 32'h00000070);
    rdc(8'h28, 32'h00000044);
    // Random OUT traffic on the general endpoints, every outcome case
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      ep = 3'(1 + seed % 5);
      cs = (i < 7) ? i : int'(seed[10:8]) % 7;
      w = {seed[22:20], 2'b10, 1'b0, seed[18] & seed[19], seed[16] & seed[17]};
      c = w & 8'hE3;
      mp = {3'h0, seed[31:24]} + 11'h001;
      bus(8'h44 + {3'h0, ep, 2'h0}, 1'b1, 32'h0000007F);
      bus(8'h24 + {3'h0, ep, 2'h0}, 1'b1, {24'h0, w});
      i_host.run(uetc_pkg::UETC_K_OUT, ep, (cs == 5) ? {1'b0, mp} : {1'b0, mp} + 12'(seed[3:0]) + 12'h001,
                 mp, {1'b0, cs == 3, cs == 2, cs == 4, cs == 1, cs == 6, 1'b0}, 64'h0);
      e = exp_out(c, cs);
      check(i_host.got_acc, !c[1] && !c[0] && cs != 5);
      check(i_host.got_v, e[18:16] != uetc_pkg::UETC_HS_NONE);
      if (i_host.got_v === 1'b1) check(i_host.got_hs, e[18:16]);
      check(i_host.got_cm, e[0]);
      if (e[0]) check(i_host.got_cep, ep);
      rdc(8'h44 + {3'h0, ep, 2'h0}, {25'h0, e[15:9]});
      rdc(8'h24 + {3'h0, ep, 2'h0}, {24'h0, e[8:1]});
    end
    print_verdict();
  end
endmodule : usb_endpoint_transaction_ctrl_bench
